// ### core/button_debounce.sv
// Synchroniser and debouncer for the active-low power button
`timescale 1ns/1ns
`default_nettype none
`include "power_button_map.svh"

module button_debounce #(
  parameter int unsigned DEBOUNCE_CYCLES = `PB_DEBOUNCE_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Button pin
  input  wire logic button_n,
  // Debounced button
  button_if.src     btn
);

  logic        sync1_q;
  logic        sync2_q;
  logic        pressed_q;
  logic        press_q;
  logic        release_q;
  logic [31:0] cnt_q;
  logic        differs;
  logic        settle;

  assign differs = (~sync2_q) != pressed_q;
  assign settle  = differs && (cnt_q == 32'(DEBOUNCE_CYCLES - 1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= button_n;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 32'h0000_0000;
    end else if (!differs || settle) begin
      cnt_q <= 32'h0000_0000;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

  // Falling edge of pin gives press
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pressed_q <= 1'b0;
      press_q   <= 1'b0;
      release_q <= 1'b0;
    end else begin
      pressed_q <= settle ? ~pressed_q : pressed_q;
      press_q   <= settle && !pressed_q;
      release_q <= settle && pressed_q;
    end
  end

  assign btn.pressed     = pressed_q;
  assign btn.press       = press_q;
  assign btn.release_evt = release_q;

endmodule

`default_nettype wire

// ### core/power_button_supply_control.sv
// Power button to supply on-request controller with AXI4-Lite registers
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "power_button_map.svh"

module power_button_supply_control #(
  parameter int unsigned GUARD_CYCLES    = `PB_GUARD_CYCLES,
  parameter int unsigned DEBOUNCE_CYCLES = `PB_DEBOUNCE_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Button and supply
  input  wire logic        button_n,
  output logic             supply_on_request,
  output logic             system_mgmt_interrupt_n,
  output logic             irq,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  button_if btn ();

  button_debounce #(
    .DEBOUNCE_CYCLES (DEBOUNCE_CYCLES)
  ) u_debounce (
    .button_n (button_n),
    .clk      (clk),
    .rst      (rst),
    .btn      (btn.src)
  );

  power_button_pkg::power_state_type state_q;

  logic                     acpi_en_q;
  logic                     btn_status_q;
  logic                     smi_src_q;
  logic                     guard_active_q;
  logic [31:0]              guard_cnt_q;
  logic [31:0]              hold_cnt_q;
  logic [`PB_INT_WIDTH-1:0] int_status_q;
  logic [`PB_INT_WIDTH-1:0] int_mask_q;
  logic [`PB_INT_WIDTH-1:0] int_set;
  logic                     aw_held_q;
  logic                     w_held_q;
  logic [7:0]               awaddr_q;
  logic [31:0]              wdata_q;
  logic [3:0]               wstrb_q;
  logic                     bvalid_q;
  logic [1:0]               bresp_q;
  logic                     rvalid_q;
  logic [1:0]               rresp_q;
  logic [31:0]              rdata_q;
  logic [31:0]              rd_word;
  logic                     rd_hit;
  logic                     wr_hit;
  logic                     wr_fire;
  logic                     wr_low;
  logic                     on_acpi;
  logic                     on_cause;
  logic                     acpi_press;
  logic                     plain_off;
  logic                     guard_expire;
  logic                     held_long;
  logic                     long_release;
  logic                     off_cause;
  logic                     clr_btn;
  logic                     clr_smi;

  // Event decode
  assign on_acpi      = (state_q == power_button_pkg::st_on) && acpi_en_q;
  assign on_cause     = (state_q == power_button_pkg::st_off) && btn.press;
  assign plain_off    = (state_q == power_button_pkg::st_on) && !acpi_en_q
                        && btn.press;
  assign guard_expire = guard_active_q && btn_status_q
                        && (guard_cnt_q == 32'(GUARD_CYCLES - 1));
  assign held_long    = hold_cnt_q == 32'(GUARD_CYCLES);
  assign long_release = on_acpi && btn.release_evt && held_long;
  assign off_cause    = plain_off || guard_expire || long_release;
  assign acpi_press   = on_acpi && btn.press && !off_cause;

  // Write decode
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign wr_low  = wr_fire && wstrb_q[0];
  assign clr_btn = wr_low && (awaddr_q == `PB_REG_STATUS)
                   && wdata_q[`PB_STATUS_BTN];
  assign clr_smi = wr_low && (awaddr_q == `PB_REG_SMI_SRC)
                   && wdata_q[`PB_SMI_SRC_BTN];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= power_button_pkg::st_off;
    end else begin
      unique case (state_q)
        power_button_pkg::st_off: begin
          if (on_cause) begin
            state_q <= power_button_pkg::st_on;
          end
        end
        power_button_pkg::st_on: begin
          if (off_cause) begin
            state_q <= power_button_pkg::st_off;
          end
        end
      endcase
    end
  end

  assign supply_on_request = state_q == power_button_pkg::st_on;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      btn_status_q <= 1'b0;
    end else if (acpi_press) begin
      btn_status_q <= 1'b1;
    end else if (off_cause || clr_btn) begin
      btn_status_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      smi_src_q <= 1'b0;
    end else if (acpi_press) begin
      smi_src_q <= 1'b1;
    end else if (off_cause || clr_smi) begin
      smi_src_q <= 1'b0;
    end
  end

  assign system_mgmt_interrupt_n = ~smi_src_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      guard_active_q <= 1'b0;
      guard_cnt_q    <= 32'h0000_0000;
    end else if (off_cause) begin
      guard_active_q <= 1'b0;
      guard_cnt_q    <= 32'h0000_0000;
    end else if (acpi_press) begin
      guard_active_q <= 1'b1;
      guard_cnt_q    <= 32'h0000_0000;
    end else if (clr_btn) begin
      guard_active_q <= 1'b0;
      guard_cnt_q    <= 32'h0000_0000;
    end else if (guard_active_q) begin
      guard_cnt_q    <= guard_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_cnt_q <= 32'h0000_0000;
    end else if (!(on_acpi && btn.pressed) || btn.press) begin
      hold_cnt_q <= 32'h0000_0000;
    end else if (!held_long) begin
      hold_cnt_q <= hold_cnt_q + 32'h0000_0001;
    end
  end

  // Control and interrupt mask registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acpi_en_q  <= 1'b0;
      int_mask_q <= '0;
    end else if (wr_low) begin
      if (awaddr_q == `PB_REG_CTRL) begin
        acpi_en_q <= wdata_q[`PB_CTRL_ACPI_EN];
      end
      if (awaddr_q == `PB_REG_INT_MASK) begin
        int_mask_q <= wdata_q[`PB_INT_WIDTH-1:0];
      end
    end
  end

  // Sticky interrupt status, set wins over clear
  always_comb begin
    int_set = '0;
    int_set[`PB_INT_POWER_ON]     = on_cause;
    int_set[`PB_INT_POWER_OFF]    = off_cause;
    int_set[`PB_INT_ACPI_PRESS]   = acpi_press;
    int_set[`PB_INT_GUARD_EXPIRE] = guard_expire;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_status_q <= '0;
    end else if (wr_low && (awaddr_q == `PB_REG_INT_STATUS)) begin
      int_status_q <= (int_status_q & ~wdata_q[`PB_INT_WIDTH-1:0]) | int_set;
    end else begin
      int_status_q <= int_status_q | int_set;
    end
  end

  assign irq = |(int_status_q & int_mask_q);

  // Write channel capture
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w_held_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  assign wr_hit = (awaddr_q == `PB_REG_CTRL) || (awaddr_q == `PB_REG_STATUS)
                  || (awaddr_q == `PB_REG_SMI_SRC)
                  || (awaddr_q == `PB_REG_INT_STATUS)
                  || (awaddr_q == `PB_REG_INT_MASK);

  // Write response
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `PB_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? `PB_RESP_OKAY : `PB_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // Read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr)
      `PB_REG_CTRL: begin
        rd_word[`PB_CTRL_ACPI_EN] = acpi_en_q;
      end
      `PB_REG_STATUS: begin
        rd_word[`PB_STATUS_BTN]       = btn_status_q;
        rd_word[`PB_STATUS_SUPPLY_ON] = supply_on_request;
        rd_word[`PB_STATUS_GUARD]     = guard_active_q;
        rd_word[`PB_STATUS_PRESSED]   = btn.pressed;
      end
      `PB_REG_SMI_SRC: begin
        rd_word[`PB_SMI_SRC_BTN] = smi_src_q;
      end
      `PB_REG_INT_STATUS: begin
        rd_word[`PB_INT_WIDTH-1:0] = int_status_q;
      end
      `PB_REG_INT_MASK: begin
        rd_word[`PB_INT_WIDTH-1:0] = int_mask_q;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rresp_q  <= `PB_RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q  <= rd_hit ? `PB_RESP_OKAY : `PB_RESP_SLVERR;
      rdata_q  <= rd_word;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp  = rresp_q;
  assign s_axi_rdata  = rdata_q;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_acpi_press;
    acpi_press;
  endsequence

  sequence s_smi_raised;
    !system_mgmt_interrupt_n && btn_status_q && smi_src_q
      && guard_active_q && (guard_cnt_q == 32'h0000_0000);
  endsequence

  sequence s_guard_runs;
    guard_active_q && (guard_cnt_q == 32'h0000_0001);
  endsequence

  property p_off_press;
    on_cause |=> supply_on_request;
  endproperty
  a_off_press: assert property (p_off_press)
    else $error("press while off did not raise on-request");

  property p_fall_cause;
    $fell(supply_on_request) |-> $past(off_cause);
  endproperty
  a_fall_cause: assert property (p_fall_cause)
    else $error("on-request dropped without a cause");

  property p_off_quiet;
    !supply_on_request |-> !guard_active_q && !btn_status_q;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("guard active while supply off");

  property p_plain_off;
    plain_off |=> !supply_on_request && !guard_active_q;
  endproperty
  a_plain_off: assert property (p_plain_off)
    else $error("press with ACPI off did not drop on-request");

  property p_acpi_press;
    s_acpi_press |=> s_smi_raised ##1 (s_guard_runs or !guard_active_q);
  endproperty
  a_acpi_press: assert property (p_acpi_press)
    else $error("ACPI press did not raise SMI, status and guard");

  property p_guard_expire;
    guard_expire |=> !supply_on_request && !guard_active_q;
  endproperty
  a_guard_expire: assert property (p_guard_expire)
    else $error("guard expiry did not drop on-request");

  property p_long_release;
    long_release |=> !supply_on_request ##1 !supply_on_request;
  endproperty
  a_long_release: assert property (p_long_release)
    else $error("long hold release did not drop on-request");

  property p_clear_stops;
    $fell(btn_status_q) |-> !guard_active_q;
  endproperty
  a_clear_stops: assert property (p_clear_stops)
    else $error("guard still running after status clear");

endmodule

`default_nettype wire

// ### include/button_if.sv
// Debounced button level and edge pulses between debouncer and controller
`timescale 1ns/1ns
`default_nettype none

interface button_if;
  logic pressed;
  logic press;
  logic release_evt;

  modport src (
    output pressed,
    output press,
    output release_evt
  );

  modport dst (
    input pressed,
    input press,
    input release_evt
  );
endinterface

`default_nettype wire

// ### include/power_button_map.svh
// Register map, field positions and timing counts for the power button block
`ifndef POWER_BUTTON_MAP_SVH
`define POWER_BUTTON_MAP_SVH

// Timing
`define PB_CLK_MHZ           125
`define PB_GUARD_TIME_S      4
`define PB_DEBOUNCE_TIME_US  10000
`define PB_GUARD_CYCLES      (`PB_GUARD_TIME_S * `PB_CLK_MHZ * 1000000)
`define PB_DEBOUNCE_CYCLES   (`PB_DEBOUNCE_TIME_US * `PB_CLK_MHZ)

// Register byte offsets
`define PB_REG_CTRL          8'h00
`define PB_REG_STATUS        8'h04
`define PB_REG_SMI_SRC       8'h08
`define PB_REG_INT_STATUS    8'h0c
`define PB_REG_INT_MASK      8'h10

// Control fields
`define PB_CTRL_ACPI_EN      0

// Status fields
`define PB_STATUS_BTN        0
`define PB_STATUS_SUPPLY_ON  1
`define PB_STATUS_GUARD      2
`define PB_STATUS_PRESSED    3

// Interrupt source fields
`define PB_SMI_SRC_BTN       0

// Interrupt event fields
`define PB_INT_POWER_ON      0
`define PB_INT_POWER_OFF     1
`define PB_INT_ACPI_PRESS    2
`define PB_INT_GUARD_EXPIRE  3
`define PB_INT_WIDTH         4

// Bus responses
`define PB_RESP_OKAY         2'h0
`define PB_RESP_SLVERR       2'h2

`endif

// ### include/power_button_pkg.sv
// Types shared by the power button block
package power_button_pkg;

  typedef enum logic {
    st_off,
    st_on
  } power_state_type;

endpackage

// ### verification/power_button_supply_control_test.sv
// Register-level bench for the power button controller
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
  bad_count++; $display("ERROR %s exp %h got %h", nm, e, g); end end

module power_button_supply_control_test;
  localparam int GUARD = 200;
  localparam int LIMIT = 6000;

  logic        clk;
  logic        rst;
  logic        button_n;
  logic        supply_on_request;
  logic        system_mgmt_interrupt_n;
  logic        irq;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        hold;
  logic        bounce;
  logic        rails_on;
  logic        aux_on;
  int          bad_count;
  int          checks;
  int          cycles;

  power_button_supply_control #(
    .GUARD_CYCLES    (GUARD),
    .DEBOUNCE_CYCLES (4)
  ) u_power_button_supply_control (
    .clk (clk), .rst (rst), .button_n (button_n),
    .supply_on_request (supply_on_request),
    .system_mgmt_interrupt_n (system_mgmt_interrupt_n), .irq (irq),
    .s_axi_awaddr (awaddr), .s_axi_awvalid (awvalid),
    .s_axi_awready (awready), .s_axi_wdata (wdata), .s_axi_wstrb (wstrb),
    .s_axi_wvalid (wvalid), .s_axi_wready (wready), .s_axi_bresp (bresp),
    .s_axi_bvalid (bvalid), .s_axi_bready (bready),
    .s_axi_araddr (araddr), .s_axi_arvalid (arvalid),
    .s_axi_arready (arready), .s_axi_rdata (rdata), .s_axi_rresp (rresp),
    .s_axi_rvalid (rvalid), .s_axi_rready (rready)
  );

  power_supply_model u_power_supply_model (
    .clk (clk), .rst (rst), .hold (hold), .bounce (bounce),
    .supply_on_request (supply_on_request), .button_n (button_n),
    .rails_on (rails_on), .aux_on (aux_on)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = !clk;
  end

  task results;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      $display("ERROR timeout exp %0d got %0d", LIMIT - 1, cycles);
      results();
    end
  end

  // Write one word, compare response
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
  endtask

  // Read one word, compare masked data and response
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
          input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    `CHK("rdata", e, rdata & m)
    `CHK("rresp", er, rresp)
  endtask

  // Press for n cycles, then let the release settle
  task push(input int n, input logic b);
    bounce <= b;
    hold <= 1'b1;
    repeat (n) @(posedge clk);
    hold <= 1'b0;
    repeat (16) @(posedge clk);
  endtask

  initial begin
    bad_count = 0;
    checks = 0;
    cycles = 0;
    rst = 1'b1;
    hold = 1'b0;
    bounce = 1'b0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("supply", 1'b0, supply_on_request)
    `CHK("smi_n", 1'b1, system_mgmt_interrupt_n)
    rd(8'h00, 32'hffffffff, 32'h0, 2'h0);
    rd(8'h10, 32'hffffffff, 32'h0, 2'h0);
    rd(8'h14, 32'hffffffff, 32'h0, 2'h2);
    wr(8'h14, 32'h1, 2'h2);
    $display("test reset done");
    push(12, 1'b0);
    `CHK("supply", 1'b1, supply_on_request)
    `CHK("rails", 1'b1, rails_on)
    rd(8'h04, 32'hf, 32'h2, 2'h0);
    wr(8'h10, 32'h1, 2'h0);
    `CHK("irq", 1'b1, irq)
    wr(8'h0c, 32'h1, 2'h0);
    `CHK("irq", 1'b0, irq)
    wr(8'h10, 32'h8, 2'h0);
    $display("test power on done");
    push(12, 1'b1);
    `CHK("supply", 1'b0, supply_on_request)
    `CHK("rails", 1'b0, rails_on)
    `CHK("aux", 1'b1, aux_on)
    rd(8'h04, 32'hf, 32'h0, 2'h0);
    rd(8'h0c, 32'h2, 32'h2, 2'h0);
    $display("test plain off done");
    push(12, 1'b0);
    wr(8'h00, 32'h1, 2'h0);
    push(12, 1'b0);
    `CHK("smi_n", 1'b0, system_mgmt_interrupt_n)
    rd(8'h08, 32'h1, 32'h1, 2'h0);
    rd(8'h04, 32'h5, 32'h5, 2'h0);
    wr(8'h04, 32'h1, 2'h0);
    wr(8'h08, 32'h1, 2'h0);
    `CHK("smi_n", 1'b1, system_mgmt_interrupt_n)
    rd(8'h04, 32'h5, 32'h0, 2'h0);
    repeat (GUARD + 20) @(posedge clk);
    `CHK("supply", 1'b1, supply_on_request)
    rd(8'h0c, 32'h4, 32'h4, 2'h0);
    $display("test acpi cleared done");
    push(12, 1'b0);
    repeat (GUARD - 40) @(posedge clk);
    `CHK("supply", 1'b1, supply_on_request)
    `CHK("irq", 1'b0, irq)
    repeat (60) @(posedge clk);
    `CHK("supply", 1'b0, supply_on_request)
    `CHK("irq", 1'b1, irq)
    rd(8'h04, 32'h1, 32'h0, 2'h0);
    wr(8'h0c, 32'hf, 2'h0);
    `CHK("irq", 1'b0, irq)
    $display("test guard expiry done");
    push(12, 1'b0);
    `CHK("supply", 1'b1, supply_on_request)
    hold <= 1'b1;
    repeat (16) @(posedge clk);
    wr(8'h04, 32'h1, 2'h0);
    wr(8'h08, 32'h1, 2'h0);
    repeat (GUARD) @(posedge clk);
    `CHK("supply", 1'b1, supply_on_request)
    hold <= 1'b0;
    repeat (16) @(posedge clk);
    `CHK("supply", 1'b0, supply_on_request)
    $display("test long hold done");
    results();
  end
endmodule

`default_nettype wire

// ### verification/power_supply_model.sv
// Behavioural front-panel button and supply assembly
`timescale 1ns/1ns
`default_nettype none

module power_supply_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Bench commands
  input  wire logic hold,
  input  wire logic bounce,
  // Controller side
  input  wire logic supply_on_request,
  output logic      button_n,
  output logic      rails_on,
  output logic      aux_on
);
  logic [1:0] contact_q;
  logic [1:0] rails_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      contact_q <= 2'h0;
    end else begin
      contact_q <= {contact_q[0], hold};
    end
  end

  assign button_n = !hold || (bounce && contact_q == 2'h1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rails_q <= 2'h0;
    end else begin
      rails_q <= {rails_q[0], supply_on_request};
    end
  end
  assign rails_on = rails_q[1];

  assign aux_on = 1'b1;
endmodule

`default_nettype wire
